// ### common/acc_pkg.sv
// constants and types for the compare, averaging and calibration block
package acc_pkg;

    // ==================================================
    // register byte offsets
    localparam logic [7:0] OFF_CTRL_SET   = 8'h00;  // channel_control_set: flag, complete
    localparam logic [7:0] OFF_STAT_TWO   = 8'h04;  // status_control_two
    localparam logic [7:0] OFF_STAT_THREE = 8'h08;  // status_control_three
    localparam logic [7:0] OFF_RESULT     = 8'h0c;
    localparam logic [7:0] OFF_THR_FIRST  = 8'h10;
    localparam logic [7:0] OFF_THR_SECOND = 8'h14;
    localparam logic [7:0] OFF_PLUS_GAIN  = 8'h18;
    localparam logic [7:0] OFF_MINUS_GAIN = 8'h1c;
    localparam logic [7:0] OFF_IRQ_STAT   = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h24;
    localparam logic [7:0] OFF_PLUS_CAL0  = 8'h40;  // six words: plus_cal_result_0..s
    localparam logic [7:0] OFF_MINUS_CAL0 = 8'h60;  // six words: minus_cal_result_0..s
    localparam int         CAL_WORDS      = 6;

    // ==================================================
    // field positions
    localparam int CTRL_CONVERSION_COMPLETE_FLAG_BIT   = 7;   // conversion_complete_flag
    localparam int TWO_TRG_BIT     = 6;   // hardware_trigger_select
    localparam int TWO_CMPEN_BIT   = 5;
    localparam int TWO_GT_BIT      = 4;   // cmp_greater_select
    localparam int TWO_RANGE_BIT   = 3;   // cmp_range_enable
    localparam int TWO_DMA_BIT     = 2;   // dma_request_enable
    localparam int THREE_CAL_BIT   = 7;
    localparam int THREE_CALIBRATION_FAIL_FLAG_BIT  = 6;   // calibration_fail_flag
    localparam int THREE_AVERAGING_ENABLE_BIT  = 2;   // averaging_enable
    localparam int THREE_AVGS_LSB  = 0;
    localparam int IRQ_CONVERSION_COMPLETE_FLAG_BIT    = 0;
    localparam int IRQ_CMP_BIT     = 1;
    localparam int IRQ_CALIBRATION_FAIL_FLAG_BIT    = 2;
    localparam int IRQ_W           = 3;

    // ==================================================
    // reset values
    localparam logic [15:0] GAIN_RESET  = 16'h8200;
    localparam logic [15:0] THR_RESET   = 16'h0000;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;

    // ==================================================
    // calibration timing and limits
    localparam int          CAL_STEP_NS     = 100;
    localparam int          CLK_NS          = 10;
    localparam int          CAL_STEP_CYC    = (CAL_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] CAL_FAIL_LIMIT  = 16'hf000;

    typedef enum logic [1:0] {
        ACC_AVG_4,
        ACC_AVG_8,
        ACC_AVG_16,
        ACC_AVG_32
    } acc_avg_sel_t;

endpackage : acc_pkg

// ### rtl/acc_compare.sv
// six-mode threshold compare on one conversion result
`timescale 1ns/1ps
module acc_compare (
    input  wire logic [15:0] result,
    input  wire logic [15:0] threshold_first,
    input  wire logic [15:0] threshold_second,
    input  wire logic        cmp_greater_select,
    input  wire logic        cmp_range_enable,
    output logic             cmp_true
);
    import acc_pkg::*;

    logic first_le_second;
    logic below_first;
    logic above_second;

    assign first_le_second = threshold_first <= threshold_second;         // [R1]
    assign below_first     = result < threshold_first;
    assign above_second    = result > threshold_second;

    always_comb begin
        unique case ({cmp_greater_select, cmp_range_enable})              // [R1]
            2'b00: cmp_true = below_first;                                // [R3]
            2'b10: cmp_true = !below_first;                               // [R4]
            2'b01: cmp_true = first_le_second ? (below_first || above_second)   // [R5]
                                              : (below_first && above_second);  // [R6]
            2'b11: cmp_true = first_le_second ? (!below_first && !above_second)
                                              : (!below_first || !above_second); // [R7]
        endcase
    end

endmodule : acc_compare

// ### rtl/acc_average.sv
// accumulates 4 to 32 results and emits their mean
`timescale 1ns/1ps
module acc_average (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 enable,
    input  wire acc_pkg::acc_avg_sel_t count_sel,
    input  wire logic                 sample_valid,
    input  wire logic [15:0]          sample,
    output logic                      mean_valid,
    output logic [15:0]               mean
);
    import acc_pkg::*;

    logic [20:0] sum_reg;
    logic [5:0]  cnt_reg;
    logic [5:0]  target;
    logic [20:0] sum_next;

    always_comb begin
        unique case (count_sel)                                             // [R8]
            ACC_AVG_4:  target = 6'h04;
            ACC_AVG_8:  target = 6'h08;
            ACC_AVG_16: target = 6'h10;
            ACC_AVG_32: target = 6'h20;
        endcase
    end

    assign sum_next = sum_reg + {5'h00, sample};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_reg    <= 21'h000000;
            cnt_reg    <= 6'h00;
            mean_valid <= 1'b0;
            mean       <= 16'h0000;
        end else begin
            mean_valid <= 1'b0;
            if (!enable) begin
                sum_reg <= 21'h000000;
                cnt_reg <= 6'h00;
                if (sample_valid) begin
                    mean_valid <= 1'b1;
                    mean       <= sample;
                end
            end else if (sample_valid) begin
                if (cnt_reg + 6'h01 == target) begin                        // [R8]
                    mean_valid <= 1'b1;
                    unique case (count_sel)
                        ACC_AVG_4:  mean <= sum_next[17:2];
                        ACC_AVG_8:  mean <= sum_next[18:3];
                        ACC_AVG_16: mean <= sum_next[19:4];
                        ACC_AVG_32: mean <= sum_next[20:5];
                    endcase
                    sum_reg <= 21'h000000;
                    cnt_reg <= 6'h00;
                end else begin
                    sum_reg <= sum_next;
                    cnt_reg <= cnt_reg + 6'h01;
                end
            end
        end
    end

endmodule : acc_average

// ### rtl/acc_top.sv
// converter post-processing: compare, averaging, calibration, dma, apb registers
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// [R1] compare mode from select, range, threshold order
// [R2] compare only on a finished conversion result
// [R3] mode 00: true when result below first
// [R4] mode 10: true when result at/above first
// [R5] mode 01, first<=second: below first or above second
// [R6] mode 01, first>second: below first and above second
// [R7] mode 11: inclusive inside, else inclusive outside
// [R8] averaging enable; count code picks 4..32
// [R9] software calibrates or loads values after reset
// [R10] software configures clock, reference, timing before calibrating
// [R11] calibrate with 32-sample averaging, slow clock
// [R12] software forms gains from six calibration sums
// [R13] software selects software trigger before calibration
// [R14] failure flag set when calibration fails
// [R15] dma request on each complete when enabled
// [R16] cal start runs sequence, sets complete flag
module acc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_data,
    input  wire logic        hw_trigger,
    output logic             conv_start,
    output logic             dma_req,
    output logic             irq
);
    import acc_pkg::*;

    // ==================================================
    // registers
    logic [15:0]        threshold_first_reg;
    logic [15:0]        threshold_second_reg;
    logic [15:0]        plus_gain_value_reg;
    logic [15:0]        minus_gain_value_reg;
    logic [15:0]        result_reg;
    logic               conversion_complete_flag_reg;
    logic               cmp_enable_reg;
    logic               cmp_greater_select_reg;
    logic               cmp_range_enable_reg;
    logic               dma_request_enable_reg;
    logic               hardware_trigger_select_reg;
    logic               cal_start_reg;
    logic               calibration_fail_flag_reg;
    logic               averaging_enable_reg;
    acc_avg_sel_t       avg_sel_reg;
    logic [IRQ_W-1:0]   irq_stat_reg;
    logic [IRQ_W-1:0]   irq_mask_reg;
    logic [15:0]        plus_cal_mem [CAL_WORDS];
    logic [15:0]        minus_cal_mem [CAL_WORDS];

    logic               wr_en;
    logic               rd_en;
    logic               addr_ok;
    logic               cmp_true;
    logic               mean_valid;
    logic [15:0]        mean;
    logic               result_event;
    logic               cmp_event;
    logic               cal_done;
    logic               cal_fail;
    logic               cal_sample_req;
    logic [IRQ_W-1:0]   irq_events;
    logic [31:0]        rd_data;

    // ==================================================
    // trigger pin synchroniser
    logic [2:0]         trg_sync_reg;
    logic               trg_level_reg;
    logic               trg_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trg_sync_reg  <= 3'h0;
            trg_level_reg <= 1'b0;
        end else begin
            trg_sync_reg <= {trg_sync_reg[1:0], hw_trigger};
            if (trg_sync_reg[1] == trg_sync_reg[2]) begin
                trg_level_reg <= trg_sync_reg[2];
            end
        end
    end

    assign trg_rise = (trg_sync_reg[1] == trg_sync_reg[2]) && trg_sync_reg[2]
                      && !trg_level_reg;

    // ==================================================
    // apb decode
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    always_comb begin
        addr_ok = 1'b1;
        rd_data = 32'h00000000;
        if (paddr >= OFF_PLUS_CAL0 && paddr < OFF_PLUS_CAL0 + 8'(4 * CAL_WORDS)
            && paddr[1:0] == 2'h0) begin
            rd_data = {16'h0000, plus_cal_mem[3'(paddr[4:2])]};
        end else if (paddr >= OFF_MINUS_CAL0 && paddr < OFF_MINUS_CAL0 + 8'(4 * CAL_WORDS)
                     && paddr[1:0] == 2'h0) begin
            rd_data = {16'h0000, minus_cal_mem[3'(paddr[4:2])]};
        end else begin
            unique case (paddr)
                OFF_CTRL_SET:   rd_data[CTRL_CONVERSION_COMPLETE_FLAG_BIT] = conversion_complete_flag_reg;
                OFF_STAT_TWO: begin
                    rd_data[TWO_TRG_BIT]   = hardware_trigger_select_reg;
                    rd_data[TWO_CMPEN_BIT] = cmp_enable_reg;
                    rd_data[TWO_GT_BIT]    = cmp_greater_select_reg;
                    rd_data[TWO_RANGE_BIT] = cmp_range_enable_reg;
                    rd_data[TWO_DMA_BIT]   = dma_request_enable_reg;
                end
                OFF_STAT_THREE: begin
                    rd_data[THREE_CAL_BIT]  = cal_start_reg;
                    rd_data[THREE_CALIBRATION_FAIL_FLAG_BIT] = calibration_fail_flag_reg;
                    rd_data[THREE_AVERAGING_ENABLE_BIT] = averaging_enable_reg;
                    rd_data[THREE_AVGS_LSB +: 2] = avg_sel_reg;
                end
                OFF_RESULT:     rd_data[15:0] = result_reg;
                OFF_THR_FIRST:  rd_data[15:0] = threshold_first_reg;
                OFF_THR_SECOND: rd_data[15:0] = threshold_second_reg;
                OFF_PLUS_GAIN:  rd_data[15:0] = plus_gain_value_reg;
                OFF_MINUS_GAIN: rd_data[15:0] = minus_gain_value_reg;
                OFF_IRQ_STAT:   rd_data[IRQ_W-1:0] = irq_stat_reg;
                OFF_IRQ_MASK:   rd_data[IRQ_W-1:0] = irq_mask_reg;
                default:        addr_ok = 1'b0;
            endcase
        end
    end

    // one wait state: answer in the access cycle after the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
            prdata  <= (rd_en && !pready && addr_ok) ? rd_data : 32'h00000000;
        end
    end

    logic wr_take;
    assign wr_take = wr_en && pready && addr_ok;

    // ==================================================
    // software-written configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            threshold_first_reg         <= THR_RESET;
            threshold_second_reg        <= THR_RESET;
            plus_gain_value_reg         <= GAIN_RESET;
            minus_gain_value_reg        <= GAIN_RESET;
            cmp_enable_reg              <= 1'b0;
            cmp_greater_select_reg      <= 1'b0;
            cmp_range_enable_reg        <= 1'b0;
            dma_request_enable_reg      <= 1'b0;
            hardware_trigger_select_reg <= 1'b0;
            averaging_enable_reg        <= 1'b0;
            avg_sel_reg                 <= ACC_AVG_4;
            irq_mask_reg                <= '0;
        end else if (wr_take) begin
            unique case (paddr)
                OFF_THR_FIRST:  threshold_first_reg  <= pwdata[15:0];
                OFF_THR_SECOND: threshold_second_reg <= pwdata[15:0];
                OFF_PLUS_GAIN:  plus_gain_value_reg  <= pwdata[15:0];       // [R12]
                OFF_MINUS_GAIN: minus_gain_value_reg <= pwdata[15:0];       // [R12]
                OFF_STAT_TWO: begin
                    hardware_trigger_select_reg <= pwdata[TWO_TRG_BIT];    // [R13]
                    cmp_enable_reg              <= pwdata[TWO_CMPEN_BIT];
                    cmp_greater_select_reg      <= pwdata[TWO_GT_BIT];
                    cmp_range_enable_reg        <= pwdata[TWO_RANGE_BIT];
                    dma_request_enable_reg      <= pwdata[TWO_DMA_BIT];
                end
                OFF_STAT_THREE: begin
                    averaging_enable_reg <= pwdata[THREE_AVERAGING_ENABLE_BIT];
                    avg_sel_reg <= acc_avg_sel_t'(pwdata[THREE_AVGS_LSB +: 2]);
                end
                OFF_IRQ_MASK:   irq_mask_reg <= pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ==================================================
    // conversion start: software write to control, hardware pin, or calibration sample request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= (wr_take && paddr == OFF_CTRL_SET && !hardware_trigger_select_reg)
                          || (trg_rise && hardware_trigger_select_reg)
                          || cal_sample_req;
        end
    end

    // ==================================================
    // calibration sequencer
    typedef enum logic [1:0] {
        ACC_CAL_IDLE,
        ACC_CAL_WAIT,
        ACC_CAL_STEP,
        ACC_CAL_DONE
    } acc_cal_state_t;

    acc_cal_state_t cal_state_reg;
    logic [3:0]     cal_idx_reg;
    logic [7:0]     cal_tmr_reg;
    logic           cal_busy;

    assign cal_busy       = cal_state_reg != ACC_CAL_IDLE && cal_state_reg != ACC_CAL_DONE;
    assign cal_sample_req = cal_state_reg == ACC_CAL_STEP && cal_tmr_reg == 8'h00
        || cal_state_reg == ACC_CAL_WAIT && cal_tmr_reg == 8'h01 && !mean_valid;
    assign cal_done       = cal_state_reg == ACC_CAL_WAIT && mean_valid
                            && cal_idx_reg == 4'(2 * CAL_WORDS - 1);
    assign cal_fail       = cal_done && (mean >= CAL_FAIL_LIMIT || trg_level_reg
                                         && hardware_trigger_select_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_start_reg <= 1'b0;
        end else if (wr_take && paddr == OFF_STAT_THREE) begin
            cal_start_reg <= pwdata[THREE_CAL_BIT];                         // [R16]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_state_reg <= ACC_CAL_IDLE;
            cal_idx_reg   <= 4'h0;
            cal_tmr_reg   <= 8'h00;
        end else begin
            unique case (cal_state_reg)
                ACC_CAL_IDLE: begin
                    if (cal_start_reg) begin                                 // [R16]
                        cal_state_reg <= ACC_CAL_STEP;
                        cal_idx_reg   <= 4'h0;
                        cal_tmr_reg   <= 8'(CAL_STEP_CYC);
                    end
                end
                ACC_CAL_STEP: begin
                    if (cal_tmr_reg == 8'h00) begin
                        cal_state_reg <= ACC_CAL_WAIT;
                    end else begin
                        cal_tmr_reg <= cal_tmr_reg - 8'h01;
                    end
                end
                ACC_CAL_WAIT: begin
                    if (mean_valid) begin
                        if (cal_done) begin
                            cal_state_reg <= ACC_CAL_DONE;
                        end else begin
                            cal_idx_reg   <= cal_idx_reg + 4'h1;
                            cal_tmr_reg   <= 8'(CAL_STEP_CYC);
                            cal_state_reg <= ACC_CAL_STEP;
                        end
                    end else begin
                        cal_tmr_reg <= 8'(conv_done);
                    end
                end
                ACC_CAL_DONE: begin
                    if (!cal_start_reg) begin
                        cal_state_reg <= ACC_CAL_IDLE;
                    end
                end
            endcase
        end
    end

    // per-step results land in plus then minus tables
    for (genvar i = 0; i < CAL_WORDS; i++) begin : g_cal
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                plus_cal_mem[i]  <= 16'h0000;
                minus_cal_mem[i] <= 16'h0000;
            end else if (cal_state_reg == ACC_CAL_WAIT && mean_valid) begin
                if (cal_idx_reg == 4'(i)) begin
                    plus_cal_mem[i] <= mean;
                end
                if (cal_idx_reg == 4'(i + CAL_WORDS)) begin
                    minus_cal_mem[i] <= mean;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            calibration_fail_flag_reg <= 1'b0;
        end else if (cal_fail) begin
            calibration_fail_flag_reg <= 1'b1;                              // [R14]
        end else if (wr_take && paddr == OFF_STAT_THREE && pwdata[THREE_CALIBRATION_FAIL_FLAG_BIT]) begin
            calibration_fail_flag_reg <= 1'b0;
        end
    end

    // ==================================================
    // averaging and compare datapath
    acc_average u_average (
        .pclk         (pclk),
        .presetn      (presetn),
        .enable       (averaging_enable_reg),                                // [R8]
        .count_sel    (avg_sel_reg),
        .sample_valid (conv_done),
        .sample       (conv_data),
        .mean_valid   (mean_valid),
        .mean         (mean)
    );

    acc_compare u_compare (
        .result             (mean),
        .threshold_first    (threshold_first_reg),
        .threshold_second   (threshold_second_reg),
        .cmp_greater_select (cmp_greater_select_reg),
        .cmp_range_enable   (cmp_range_enable_reg),
        .cmp_true           (cmp_true)
    );

    // result stored only when compare passes (or compare off)
    assign result_event = mean_valid && !cal_busy
                          && (!cmp_enable_reg || cmp_true);                 // [R2]
    assign cmp_event    = mean_valid && !cal_busy && cmp_enable_reg && cmp_true;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= 16'h0000;
        end else if (result_event) begin
            result_reg <= mean;
        end
    end

    // complete flag: set wins; cleared by reading the result or control write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_complete_flag_reg <= 1'b0;
        end else if (result_event || cal_done) begin
            conversion_complete_flag_reg <= 1'b1;                           // [R16]
        end else if ((rd_en && pready && paddr == OFF_RESULT)
                     || (wr_take && paddr == OFF_CTRL_SET)) begin
            conversion_complete_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_req <= 1'b0;
        end else begin
            dma_req <= dma_request_enable_reg && (result_event || cal_done); // [R15]
        end
    end

    // ==================================================
    // interrupts
    always_comb begin
        irq_events               = '0;
        irq_events[IRQ_CONVERSION_COMPLETE_FLAG_BIT] = result_event || cal_done;
        irq_events[IRQ_CMP_BIT]  = cmp_event;
        irq_events[IRQ_CALIBRATION_FAIL_FLAG_BIT] = cal_fail;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= irq_events | (irq_stat_reg
                            & ~((wr_take && paddr == OFF_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_events | irq_stat_reg) & irq_mask_reg);
        end
    end

endmodule : acc_top

// ### testbench/acc_properties.sv
// port assertions for the post-processing block
`timescale 1ns/1ps
module acc_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        conv_done,
    input wire logic        conv_start,
    input wire logic        dma_req,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // apb access steps
    sequence s_first_access;
        psel && penable && !$past(penable);
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_access_answer: assert property (s_first_access |=> s_answer) else $error("late pready");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    a_error_qualified: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad pslverr");
    a_start_pulse: assert property (conv_start |=> !conv_start) else $error("long conv_start");
    a_dma_cause: assert property (dma_req |-> $past(conv_done, 2)) else $error("stray dma_req");
    a_dma_pulse: assert property (dma_req && !$past(conv_done) |=> !dma_req) else $error("long dma_req");
    a_reset_quiet: assert property ($rose(presetn) |-> !pready && !dma_req && !irq && !conv_start)
        else $error("active after reset");
    c_dma_seen: cover property (dma_req);
endmodule : acc_properties

bind acc_top acc_properties i_acc_properties (.pclk, .presetn, .psel, .penable, .prdata, .pready,
    .pslverr, .conv_done, .conv_start, .dma_req, .irq);

// ### testbench/acc_top_tb.sv
// self-checking bench for the post-processing block
`timescale 1ns/1ps
module acc_top_tb;
    import acc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, conv_done, hw_trigger, err, auto_reply;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, conv_start, dma_req, irq;
    logic [15:0] conv_data, s;
    int          fails, check_count, cycles;
    logic [1:0]  md [9] = '{0, 0, 2, 1, 1, 1, 3, 3, 3};
    logic [15:0] c1 [9] = '{100, 100, 100, 100, 100, 200, 100, 200, 200};
    logic [15:0] c2 [9] = '{200, 200, 200, 200, 200, 100, 200, 100, 100};
    logic [15:0] v [9]  = '{99, 100, 100, 201, 200, 150, 200, 150, 100};
    logic        ex [9] = '{1, 0, 1, 1, 0, 1, 1, 0, 1};
    acc_top i_acc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .conv_done, .conv_data, .hw_trigger, .conv_start, .dma_req, .irq);
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    // converter stand-in
    always @(posedge pclk) begin
        cycles++;
        if (auto_reply) conv_done <= conv_start;
        if (cycles == 30000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conv(input logic [15:0] d);
        conv_done <= 1'b1;
        conv_data <= d;
        @(posedge pclk);
        conv_done <= 1'b0;
        @(posedge pclk);
    endtask : conv
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    initial begin
        {fails, check_count, cycles} = 0;
        {psel, penable, pwrite, conv_done, hw_trigger, auto_reply, presetn} = 0;
        {paddr, pwdata, conv_data} = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, OFF_PLUS_GAIN, 0);
        chk(rd, {16'h0, GAIN_RESET});
        apb(1, OFF_MINUS_GAIN, {16'h0, GAIN_RESET});
        apb(0, 8'h30, 0);
        chk(err, 1'b1);
        $display("test registers done");
        for (int i = 0; i < 9; i++) begin
            apb(1, OFF_THR_FIRST, c1[i]);
            apb(1, OFF_THR_SECOND, c2[i]);
            apb(1, OFF_STAT_TWO, 32'h20 | (md[i] << TWO_RANGE_BIT));
            conv(v[i]);
            apb(0, OFF_CTRL_SET, 0);
            chk(rd[CTRL_CONVERSION_COMPLETE_FLAG_BIT], ex[i]);
            apb(0, OFF_RESULT, 0);
            if (ex[i]) chk(rd, v[i]);
        end
        $display("test compare done");
        apb(1, OFF_STAT_TWO, 32'h04);
        apb(1, OFF_STAT_THREE, 32'h04);
        apb(1, OFF_IRQ_MASK, 32'h01);
        conv(10);
        conv(20);
        conv(30);
        conv(41);
        @(posedge pclk);
        chk(dma_req, 1'b1);
        apb(0, OFF_RESULT, 0);
        chk(rd, 25);
        chk(irq, 1'b1);
        apb(1, OFF_IRQ_STAT, 32'h01);
        apb(1, OFF_IRQ_MASK, 32'h00);
        chk(irq, 1'b0);
        $display("test average done");
        for (int j = 0; j < 2; j++) begin
            conv_data  <= j ? 16'hf000 : 16'h1234;
            auto_reply <= 1'b1;
            apb(1, OFF_STAT_TWO, 0);
            apb(1, OFF_STAT_THREE, 32'h87);
            rd = 0;
            while (rd[CTRL_CONVERSION_COMPLETE_FLAG_BIT] !== 1'b1) apb(0, OFF_CTRL_SET, 0);
            apb(0, OFF_STAT_THREE, 0);
            chk(rd[THREE_CALIBRATION_FAIL_FLAG_BIT], j[0]);
            s = 0;
            for (int k = 0; k < 12; k++) begin
                apb(0, (k < 6 ? OFF_PLUS_CAL0 : OFF_MINUS_CAL0) + 8'(4 * (k % 6)), 0);
                chk(rd, conv_data);
                if (k < 6) s += conv_data;
            end
            apb(1, OFF_PLUS_GAIN, (s >> 1) | 16'h8000);
            apb(0, OFF_PLUS_GAIN, 0);
            chk(rd, (s >> 1) | 16'h8000);
            apb(1, OFF_STAT_THREE, 32'h47);
            apb(0, OFF_RESULT, 0);
            apb(0, OFF_IRQ_STAT, 0);
            chk(rd[IRQ_CALIBRATION_FAIL_FLAG_BIT], j[0]);
            chk(irq, 1'b0);
        end
        $display("test calibration done");
        end_of_test();
    end
endmodule : acc_top_tb
